// ==== hdl/cic_comparator_interrupt_control.sv ====
// Comparator control, comparator events and analogue interrupt routing.
// Assumes raw comparator outputs are asynchronous; sleep and conversion events are on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module cic_comparator_interrupt_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Analogue side
  input  wire logic [1:0]  cmpRaw,
  input  wire logic        chipSleep,
  input  wire logic        inConvDone,
  output logic      [1:0]  cmpEnable,
  output logic      [3:0]  cmpRefSel,
  output logic      [3:0]  cmpHystSel,
  output logic             cmpLowPower,
  // Interrupts and wake
  output logic             sysCtrlIrq,
  output logic             cmpWakeReq,
  output logic             analogueIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0][cic_pkg::CFG_WIDTH-1:0] cmpCfgQ;
  logic                               lowPowerQ;
  logic [1:0]                         irqStatQ;
  logic [1:0]                         irqEnQ;
  logic [1:0]                         wakeStatQ;
  logic                               wakeReqQ;
  logic [cic_pkg::AP_WIDTH-1:0]       apCfgQ;
  logic [1:0]                         apStatQ;
  logic [3:0]                         accCntQ;
  logic [2:0]                         syncQ [2];
  logic [1:0]                         resQ;
  logic [1:0]                         resPrevQ;
  logic [1:0]                         cmpEvent;
  logic                               ackQ;
  logic [31:0]                        rdDataQ;
  logic                               busReq;
  logic                               wrAcc;
  logic                               rdAcc;
  logic                               accLast;
  logic                               captEvt;
  logic                               accEvt;

  // Interrupt field decode, used for both comparators
  function automatic logic intFires(input logic [1:0] mode, input logic rise,
                                    input logic fall);
    intFires = (mode == cic_pkg::CIC_INT_RISE && rise) ||
               (mode == cic_pkg::CIC_INT_FALL && fall);
  endfunction

  // Last-conversion decode for summing mode
  function automatic logic isLast(input logic [1:0] sel, input logic [3:0] cnt);
    // Sixteen needs five bits before the cut back to counter width
    isLast = (cnt == 4'((5'h02 << sel) - 5'h01));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone handshake

  assign busReq = wb_cyc_i & wb_stb_i;
  // Write and read side effects happen at the edge where the master sees ack
  assign wrAcc  = busReq & ackQ & wb_we_i & wb_sel_i[0];
  assign rdAcc  = busReq & ackQ & ~wb_we_i;

  // One wait state, ack drops the cycle after it was given
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= busReq & ~ackQ;
    end
  end

  // Read data captured as ack rises; unmapped offsets read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataQ <= 32'h0000_0000;
    end else if (busReq & ~ackQ) begin
      unique case (wb_adr_i)
        cic_pkg::CMP_A_CFG_OFS: rdDataQ <= {25'h0, cmpCfgQ[0]};
        cic_pkg::CMP_B_CFG_OFS: rdDataQ <= {25'h0, cmpCfgQ[1]};
        cic_pkg::CMP_CTRL_OFS:  rdDataQ <= {31'h0, lowPowerQ};
        cic_pkg::CMP_STATE_OFS: rdDataQ <= {30'h0, resQ};
        cic_pkg::WAKE_STAT_OFS: rdDataQ <= {30'h0, wakeStatQ};
        cic_pkg::IRQ_STAT_OFS:  rdDataQ <= {30'h0, irqStatQ};
        cic_pkg::IRQ_EN_OFS:    rdDataQ <= {30'h0, irqEnQ};
        cic_pkg::AP_CFG_OFS:    rdDataQ <= {28'h0, apCfgQ};
        cic_pkg::AP_STAT_OFS:   rdDataQ <= {30'h0, apStatQ};
        default:                rdDataQ <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdDataQ;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator configuration

  // Enable, reference, hysteresis and interrupt mode per comparator
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpCfgQ[0] <= cic_pkg::CFG_RST;
      cmpCfgQ[1] <= cic_pkg::CFG_RST;
    end else if (wrAcc && wb_adr_i == cic_pkg::CMP_A_CFG_OFS) begin
      cmpCfgQ[0] <= wb_dat_i[cic_pkg::CFG_WIDTH-1:0];
    end else if (wrAcc && wb_adr_i == cic_pkg::CMP_B_CFG_OFS) begin
      cmpCfgQ[1] <= wb_dat_i[cic_pkg::CFG_WIDTH-1:0];
    end
  end

  // Shared low-power bit; any configuration write with enable set re-arms it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowPowerQ <= cic_pkg::LP_RST;
    end else if (wrAcc && (wb_adr_i == cic_pkg::CMP_A_CFG_OFS ||
                           wb_adr_i == cic_pkg::CMP_B_CFG_OFS) &&
                 wb_dat_i[cic_pkg::CFG_EN_BIT]) begin
      lowPowerQ <= 1'b1;
    end else if (wrAcc && wb_adr_i == cic_pkg::CMP_CTRL_OFS) begin
      lowPowerQ <= wb_dat_i[0];
    end
  end

  // Analogue-facing controls; sleep overrides the chosen reference
  generate
    for (genvar i = 0; i < 2; i++) begin : gCmpOut
      assign cmpEnable[i]        = cmpCfgQ[i][cic_pkg::CFG_EN_BIT];
      assign cmpRefSel[2*i +: 2] = chipSleep ? cic_pkg::REF_NEG_PIN
                                 : cmpCfgQ[i][cic_pkg::CFG_REF_LSB +: 2];
      assign cmpHystSel[2*i +: 2] = cmpCfgQ[i][cic_pkg::CFG_HYST_LSB +: 2];
    end
  endgenerate

  assign cmpLowPower = lowPowerQ;

  ////////////////////////////////////////////////////////////////////////////
  // Result synchronisers and edge detection

  generate
    for (genvar i = 0; i < 2; i++) begin : gSync
      // Three stages; a change counts once stages two and three agree
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          syncQ[i] <= 3'h0;
        end else begin
          syncQ[i] <= {syncQ[i][1:0], cmpRaw[i]};
        end
      end

      // Stopped comparator reads low and raises no edges
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          resQ[i]     <= 1'b0;
          resPrevQ[i] <= 1'b0;
        end else begin
          if (!cmpCfgQ[i][cic_pkg::CFG_EN_BIT]) begin
            resQ[i] <= 1'b0;
          end else if (syncQ[i][1] == syncQ[i][2]) begin
            resQ[i] <= syncQ[i][2];
          end
          resPrevQ[i] <= resQ[i];
        end
      end

      // Only the selected polarity produces an event
      assign cmpEvent[i] = cmpCfgQ[i][cic_pkg::CFG_EN_BIT] &&
                           intFires(cmpCfgQ[i][cic_pkg::CFG_INT_LSB +: 2],
                                    resQ[i] & ~resPrevQ[i],
                                    ~resQ[i] & resPrevQ[i]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // System-controller interrupt path

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatQ <= cic_pkg::IRQ_RST;
    end else begin
      irqStatQ <= (irqStatQ & ~((wrAcc && wb_adr_i == cic_pkg::IRQ_CLR_OFS)
                                ? wb_dat_i[1:0] : 2'h0)) | cmpEvent;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEnQ <= cic_pkg::IRQ_RST;
    end else if (wrAcc && wb_adr_i == cic_pkg::IRQ_EN_OFS) begin
      irqEnQ <= wb_dat_i[1:0];
    end
  end

  assign sysCtrlIrq = |(irqStatQ & irqEnQ);

  ////////////////////////////////////////////////////////////////////////////
  // Wake from sleep

  // Wake source held until read; an event during the read still latches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeStatQ <= 2'h0;
      wakeReqQ  <= 1'b0;
    end else begin
      wakeStatQ <= ((rdAcc && wb_adr_i == cic_pkg::WAKE_STAT_OFS) ? 2'h0 : wakeStatQ)
                   | (chipSleep ? cmpEvent : 2'h0);
      wakeReqQ  <= chipSleep & (|cmpEvent);
    end
  end

  assign cmpWakeReq = wakeReqQ;

  ////////////////////////////////////////////////////////////////////////////
  // Analogue-peripheral interrupt path

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      apCfgQ <= cic_pkg::AP_RST;
    end else if (wrAcc && wb_adr_i == cic_pkg::AP_CFG_OFS) begin
      apCfgQ <= wb_dat_i[cic_pkg::AP_WIDTH-1:0];
    end
  end

  assign accLast = isLast(apCfgQ[cic_pkg::AP_CNT_LSB +: 2], accCntQ);
  // Only input conversion completions feed this path
  assign captEvt = inConvDone & ~apCfgQ[cic_pkg::AP_ACCUM_BIT];
  assign accEvt  = inConvDone & apCfgQ[cic_pkg::AP_ACCUM_BIT] & accLast;

  // Conversion counter; restarts whenever the mode is rewritten
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accCntQ <= 4'h0;
    end else if (wrAcc && wb_adr_i == cic_pkg::AP_CFG_OFS) begin
      accCntQ <= 4'h0;
    end else if (inConvDone && apCfgQ[cic_pkg::AP_ACCUM_BIT]) begin
      accCntQ <= accLast ? 4'h0 : accCntQ + 4'h1;
    end
  end

  // Servicing the interrupt means reading its status; events still win
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      apStatQ <= 2'h0;
    end else begin
      apStatQ <= ((rdAcc && wb_adr_i == cic_pkg::AP_STAT_OFS) ? 2'h0 : apStatQ)
                 | {accEvt, captEvt};
    end
  end

  assign analogueIrq = apCfgQ[cic_pkg::AP_IRQEN_BIT] & (|apStatQ);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_ack_single: assert property (ackQ |=> !ackQ)
    else $error("ack held longer than one cycle");

  a_sleep_ref: assert property (chipSleep |-> cmpRefSel == 4'h0)
    else $error("reference not forced to negative pin in sleep");

  a_lp_on_enable: assert property (
    wrAcc && wb_adr_i == cic_pkg::CMP_A_CFG_OFS && wb_dat_i[0] |=> cmpLowPower)
    else $error("low power not set after enable write");

  a_stop_reads_low: assert property (!cmpEnable[0] |=> !resQ[0])
    else $error("stopped comparator result not low");

  a_rise_only: assert property (
    cmpCfgQ[0][cic_pkg::CFG_INT_LSB +: 2] == cic_pkg::CIC_INT_RISE && $fell(resQ[0])
    |-> !cmpEvent[0])
    else $error("falling edge fired a rising-only interrupt");

  a_event_status: assert property (
    cmpEvent[1] |=> irqStatQ[1] && (!irqEnQ[1] || sysCtrlIrq))
    else $error("comparator event missing on system interrupt");

  a_wake_hold: assert property (
    wakeStatQ[0] && !(rdAcc && wb_adr_i == cic_pkg::WAKE_STAT_OFS) |=> wakeStatQ[0])
    else $error("wake status lost without a read");

  a_wake_pulse: assert property (
    chipSleep && cmpEvent[0] |=> cmpWakeReq && wakeStatQ[0])
    else $error("wake request or wake status missing after sleep event");

  a_ap_gate: assert property (!apCfgQ[0] |-> !analogueIrq)
    else $error("analogue interrupt not gated");

  a_capture_irq: assert property (inConvDone && !apCfgQ[1] |=> apStatQ[0])
    else $error("capture interrupt missing");

  a_accum_mid: assert property (
    apCfgQ[1] && inConvDone && !accLast && !apStatQ[1] |=> !apStatQ[1])
    else $error("accumulation interrupt raised before final sum");

  a_sync_lag: assert property (
    cmpEnable[0] && $past(cmpEnable[0]) && $changed(resQ[0]) |-> resQ[0] == $past(syncQ[0][2]))
    else $error("result changed without synchroniser agreement");

  // Bus answers only a live request
  a_ack_after_req: assert property (!busReq |=> !ackQ)
    else $error("ack without a request");

  // Event polarity and routing on the system-controller side
  a_fall_only: assert property (
    cmpCfgQ[1][cic_pkg::CFG_INT_LSB +: 2] == cic_pkg::CIC_INT_FALL && $rose(resQ[1])
    |-> !cmpEvent[1])
    else $error("rising edge fired a falling-only interrupt");

  a_rise_fires: assert property (
    cmpEnable[0] && cmpCfgQ[0][cic_pkg::CFG_INT_LSB +: 2] == cic_pkg::CIC_INT_RISE &&
    $rose(resQ[0]) |-> cmpEvent[0])
    else $error("rising edge missed by a rising-only interrupt");

  a_int_off: assert property (
    cmpCfgQ[1][cic_pkg::CFG_INT_LSB +: 2] == cic_pkg::CIC_INT_OFF ||
    cmpCfgQ[1][cic_pkg::CFG_INT_LSB +: 2] == cic_pkg::CIC_INT_RSVD |-> !cmpEvent[1])
    else $error("event raised with the interrupt field off");

  a_sticky_stat: assert property (
    irqStatQ[0] && !(wrAcc && wb_adr_i == cic_pkg::IRQ_CLR_OFS && wb_dat_i[0])
    |=> irqStatQ[0])
    else $error("comparator status lost without a clear");

  // Wake only from sleep, and read clears it
  a_wake_awake: assert property (!chipSleep |=> !cmpWakeReq)
    else $error("wake request while awake");

  a_wake_clear: assert property (
    rdAcc && wb_adr_i == cic_pkg::WAKE_STAT_OFS && !chipSleep |=> wakeStatQ == 2'h0)
    else $error("wake status not cleared by its read");

  a_lp_write: assert property (
    wrAcc && wb_adr_i == cic_pkg::CMP_CTRL_OFS |=> cmpLowPower == $past(wb_dat_i[0]))
    else $error("shared low-power bit not written");

  // Analogue path: only conversions set it, a status read services it
  a_ap_source: assert property (
    !inConvDone && !(rdAcc && wb_adr_i == cic_pkg::AP_STAT_OFS) |=> $stable(apStatQ))
    else $error("analogue status changed without a conversion");

  a_ap_service: assert property (
    rdAcc && wb_adr_i == cic_pkg::AP_STAT_OFS && !inConvDone |=> apStatQ == 2'h0)
    else $error("analogue status not cleared by servicing");

  a_accum_final: assert property (
    apCfgQ[cic_pkg::AP_ACCUM_BIT] && inConvDone && accLast
    |=> apStatQ[cic_pkg::AP_ACC_BIT])
    else $error("accumulation interrupt missing after final sum");

  a_no_capt_sum: assert property (
    apCfgQ[cic_pkg::AP_ACCUM_BIT] && !apStatQ[cic_pkg::AP_CAPT_BIT]
    |=> !apStatQ[cic_pkg::AP_CAPT_BIT])
    else $error("capture interrupt raised in summing mode");

  c_rise_irq: cover property (cmpEvent[0] ##1 sysCtrlIrq);
  c_sleep_wake: cover property (chipSleep && cmpEvent[1] ##1 cmpWakeReq);
  c_accum_done: cover property (accEvt ##1 analogueIrq);
  c_fall_irq: cover property (cmpEvent[1] ##1 irqStatQ[1]);
  c_capture: cover property (captEvt ##1 analogueIrq);

endmodule

`default_nettype wire

// ==== hdl/cic_pkg.sv ====
// Constants for the comparator and analogue interrupt control block.
// Assumes a 32-bit classic Wishbone slave with byte addresses, one register per word.
// Notes on behaviour
// - Two independent comparators; each result high when input exceeds its reference.
// - Each comparator picks its reference: negative pin, matching converter, or common reference.
// - Each comparator holds a two-bit hysteresis code: 0, 5, 10 or 20 mV.
// - Writing enable starts a comparator; result readable anytime; clearing enable stops it.
// - Comparator interrupt on one chosen polarity only; one field holds enable and direction.
// - Comparator events go to the system-controller interrupt, not the analogue one.
// - Enabled comparator interrupt wakes from sleep; wake source recorded for software.
// - During sleep each reference is forced to its negative input pin.
// - One low-power bit serves both comparators; set means slow low-current mode.
// - Enabling a comparator sets low-power; software clears it for standard power.
// - Analogue interrupt comes only from input conversion completions, never output converters.
// - Analogue interrupt gated by an enable bit in the shared analogue settings.
// - Pending analogue interrupt clears itself when serviced, no clear write needed.
// - Single and repeating conversion modes raise a capture interrupt per conversion.
// - Summing mode raises one accumulation interrupt when the final sum is ready.
// - Summing mode accumulates two, four, eight or sixteen conversions.
`default_nettype none

package cic_pkg;

  // Register byte offsets
  localparam logic [7:0] CMP_A_CFG_OFS = 8'h00;
  localparam logic [7:0] CMP_B_CFG_OFS = 8'h04;
  localparam logic [7:0] CMP_CTRL_OFS  = 8'h08;
  localparam logic [7:0] CMP_STATE_OFS = 8'h0c;
  localparam logic [7:0] WAKE_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS    = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFS   = 8'h1c;
  localparam logic [7:0] AP_CFG_OFS    = 8'h20;
  localparam logic [7:0] AP_STAT_OFS   = 8'h24;

  // Comparator configuration field positions
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_REF_LSB  = 1;
  localparam int CFG_HYST_LSB = 3;
  localparam int CFG_INT_LSB  = 5;
  localparam int CFG_WIDTH    = 7;

  // Analogue configuration field positions
  localparam int AP_IRQEN_BIT = 0;
  localparam int AP_ACCUM_BIT = 1;
  localparam int AP_CNT_LSB   = 2;
  localparam int AP_WIDTH     = 4;

  // Analogue status bits
  localparam int AP_CAPT_BIT = 0;
  localparam int AP_ACC_BIT  = 1;

  // Reset values
  localparam logic [CFG_WIDTH-1:0] CFG_RST  = 7'h00;
  localparam logic                 LP_RST   = 1'b1;
  localparam logic [AP_WIDTH-1:0]  AP_RST   = 4'h0;
  localparam logic [1:0]           IRQ_RST  = 2'h0;

  // Reference source codes
  localparam logic [1:0] REF_NEG_PIN = 2'h0;
  localparam logic [1:0] REF_OUT_CNV = 2'h1;
  localparam logic [1:0] REF_COMMON  = 2'h2;

  // Hysteresis codes
  localparam logic [1:0] HYST_0MV  = 2'h0;
  localparam logic [1:0] HYST_5MV  = 2'h1;
  localparam logic [1:0] HYST_10MV = 2'h2;
  localparam logic [1:0] HYST_20MV = 2'h3;

  // Comparator interrupt mode: enable and direction in one field
  typedef enum logic [1:0] {
    CIC_INT_OFF  = 2'b00,
    CIC_INT_RISE = 2'b01,
    CIC_INT_FALL = 2'b10,
    CIC_INT_RSVD = 2'b11
  } cic_int_type;

  // Accumulation count codes: 2, 4, 8, 16 conversions
  localparam logic [1:0] ACC_2  = 2'h0;
  localparam logic [1:0] ACC_16 = 2'h3;

endpackage

`default_nettype wire

// ==== testbench/cic_comparator_interrupt_control_tb.sv ====
// Self-checking bench for the comparator and analogue interrupt control block.
// Assumes the package and design files are compiled first; drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module cic_comparator_interrupt_control_tb;

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus signals and counters
  logic        sys_clk;
  logic        rst_n;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDat;
  logic [31:0] wbRdat;
  logic        wbAck;
  logic [1:0]  cmpRaw;
  logic        chipSleep;
  logic        inConvDone;
  logic [1:0]  cmpEnable;
  logic [3:0]  cmpRefSel;
  logic [3:0]  cmpHystSel;
  logic        cmpLowPower;
  logic        sysCtrlIrq;
  logic        cmpWakeReq;
  logic        analogueIrq;
  int          failures;
  int          testsRun;
  int          cycles;
  int          wakePulses;
  logic [31:0] rdVal;

  cic_comparator_interrupt_control u_dut (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .wb_cyc_i    (wbCyc),
    .wb_stb_i    (wbStb),
    .wb_we_i     (wbWe),
    .wb_adr_i    (wbAdr),
    .wb_sel_i    (wbSel),
    .wb_dat_i    (wbDat),
    .wb_dat_o    (wbRdat),
    .wb_ack_o    (wbAck),
    .cmpRaw      (cmpRaw),
    .chipSleep   (chipSleep),
    .inConvDone  (inConvDone),
    .cmpEnable   (cmpEnable),
    .cmpRefSel   (cmpRefSel),
    .cmpHystSel  (cmpHystSel),
    .cmpLowPower (cmpLowPower),
    .sysCtrlIrq  (sysCtrlIrq),
    .cmpWakeReq  (cmpWakeReq),
    .analogueIrq (analogueIrq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and wake pulse counter
  always #50 sys_clk = ~sys_clk;

  // Whole run is a few hundred cycles, so this only trips on a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cmpWakeReq === 1'b1) wakePulses++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helper tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Classic single cycle; read data and ack are taken at the ack edge
  task automatic wbAccess(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                          input logic [3:0] sel, output logic [31:0] rdat);
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= adr;
    wbDat <= wdat;
    wbSel <= sel;
    // No assumed wait count; only the bench hang guard ends a lost ack
    do begin
      @(posedge sys_clk);
    end while (wbAck !== 1'b1);
    rdat = wbRdat;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wdat);
    logic [31:0] dummy;
    wbAccess(1'b1, adr, wdat, 4'hf, dummy);
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp, input string name);
    logic [31:0] v;
    wbAccess(1'b0, adr, 32'h0, 4'hf, v);
    check(name, v, exp);
  endtask

  // One-cycle conversion-done pulse
  task automatic pulse;
    @(posedge sys_clk) inConvDone <= 1'b1;
    @(posedge sys_clk) inConvDone <= 1'b0;
  endtask

  function automatic logic [31:0] cfgWord(input logic en, input logic [1:0] rs,
                                          input logic [1:0] hy, input logic [1:0] md);
    return {25'h0, md, hy, rs, en};
  endfunction

  task automatic test_done;
    $display("checks %0d failures %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_clk = 1'b0; rst_n = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
    wbAdr = 8'h00; wbSel = 4'h0; wbDat = 32'h0; cmpRaw = 2'h0;
    chipSleep = 1'b0; inConvDone = 1'b0;
    failures = 0; testsRun = 0; cycles = 0; wakePulses = 0;
    tick(16);
    rst_n <= 1'b1;
    // Reset state
    check("lowpower", cmpLowPower, 1'b1);
    rdChk(cic_pkg::CMP_CTRL_OFS, 32'h1, "ctrl");
    rdChk(cic_pkg::CMP_A_CFG_OFS, 32'h0, "cfgA");
    // Enable sets low power again after software cleared it
    wr(cic_pkg::CMP_CTRL_OFS, 32'h0);
    tick(1);
    check("lpclear", cmpLowPower, 1'b0);
    wr(cic_pkg::CMP_A_CFG_OFS, cfgWord(1'b1, cic_pkg::REF_COMMON, cic_pkg::HYST_20MV, 2'b01));
    tick(1);
    check("lpenable", cmpLowPower, 1'b1);
    rdChk(cic_pkg::CMP_A_CFG_OFS, 32'h3d, "cfgAread");
    // Every reference and hysteresis code on the second comparator
    for (int i = 0; i < 4; i++) begin
      wr(cic_pkg::CMP_B_CFG_OFS, cfgWord(1'b1, 2'(i % 3), 2'(i), 2'b10));
      tick(1);
      check("refhystB", {cmpRefSel[3:2], cmpHystSel[3:2]}, {28'h0, 2'(i % 3), 2'(i)});
    end
    check("enables", cmpEnable, 2'b11);
    check("refA", cmpRefSel[1:0], cic_pkg::REF_COMMON);
    check("hystA", cmpHystSel[1:0], cic_pkg::HYST_20MV);
    wr(cic_pkg::CMP_CTRL_OFS, 32'h0);
    tick(1);
    check("lpstd", cmpLowPower, 1'b0);
    wr(cic_pkg::IRQ_EN_OFS, 32'h3);
    // Rising edge on A with rising mode
    cmpRaw <= 2'b01;
    tick(8);
    rdChk(cic_pkg::CMP_STATE_OFS, 32'h1, "stateA");
    rdChk(cic_pkg::IRQ_STAT_OFS, 32'h1, "irqA");
    check("sysirq", sysCtrlIrq, 1'b1);
    check("apirqcmp", analogueIrq, 1'b0);
    wr(cic_pkg::IRQ_STAT_OFS, 32'h0);
    rdChk(cic_pkg::IRQ_STAT_OFS, 32'h1, "irqro");
    wr(cic_pkg::IRQ_CLR_OFS, 32'h1);
    tick(1);
    check("sysirqclr", sysCtrlIrq, 1'b0);
    // Wrong-direction edges are ignored
    cmpRaw <= 2'b00;
    tick(8);
    cmpRaw <= 2'b10;
    tick(8);
    rdChk(cic_pkg::IRQ_STAT_OFS, 32'h0, "nowrongdir");
    cmpRaw <= 2'b00;
    tick(8);
    rdChk(cic_pkg::IRQ_STAT_OFS, 32'h2, "fallB");
    wr(cic_pkg::IRQ_CLR_OFS, 32'h3);
    // Masked source keeps the line low
    wr(cic_pkg::IRQ_EN_OFS, 32'h1);
    cmpRaw <= 2'b10;
    tick(8);
    cmpRaw <= 2'b00;
    tick(8);
    check("masked", sysCtrlIrq, 1'b0);
    wr(cic_pkg::IRQ_CLR_OFS, 32'h3);
    wr(cic_pkg::IRQ_EN_OFS, 32'h3);
    // Sleep forces the negative pin and records the wake source
    chipSleep <= 1'b1;
    tick(2);
    check("sleepref", cmpRefSel, 4'h0);
    cmpRaw <= 2'b01;
    tick(8);
    check("wakepulse", wakePulses, 1);
    chipSleep <= 1'b0;
    rdChk(cic_pkg::WAKE_STAT_OFS, 32'h1, "wake");
    rdChk(cic_pkg::WAKE_STAT_OFS, 32'h0, "wakeclr");
    check("wakeref", cmpRefSel, {2'h0, cic_pkg::REF_COMMON});
    wr(cic_pkg::IRQ_CLR_OFS, 32'h3);
    // Disabled comparator stops reporting
    wr(cic_pkg::CMP_A_CFG_OFS, cfgWord(1'b0, cic_pkg::REF_COMMON, cic_pkg::HYST_20MV, 2'b01));
    tick(4);
    check("disA", cmpEnable[0], 1'b0);
    rdChk(cic_pkg::CMP_STATE_OFS, 32'h0, "stateoff");
    // Capture interrupt per conversion, cleared by its status read, gated by the enable bit
    wr(cic_pkg::AP_CFG_OFS, 32'h1);
    pulse();
    tick(1);
    check("capirq", analogueIrq, 1'b1);
    rdChk(cic_pkg::AP_STAT_OFS, 32'h1, "capstat");
    tick(1);
    check("autoclr", analogueIrq, 1'b0);
    wr(cic_pkg::AP_CFG_OFS, 32'h0);
    pulse();
    tick(1);
    check("gated", analogueIrq, 1'b0);
    rdChk(cic_pkg::AP_STAT_OFS, 32'h1, "gatedstat");
    // Summing mode, every count
    for (int c = 0; c < 4; c++) begin
      wr(cic_pkg::AP_CFG_OFS, {28'h0, 2'(c), 2'b11});
      repeat ((2 << c) - 1) pulse();
      tick(1);
      check("accearly", analogueIrq, 1'b0);
      pulse();
      tick(1);
      check("accirq", analogueIrq, 1'b1);
      rdChk(cic_pkg::AP_STAT_OFS, 32'h2, "accstat");
    end
    // Unmapped read and byte-0 disabled write
    rdChk(8'h28, 32'h0, "unmapped");
    wbAccess(1'b1, cic_pkg::CMP_CTRL_OFS, 32'h1, 4'h0, rdVal);
    rdChk(cic_pkg::CMP_CTRL_OFS, 32'h0, "selzero");
    // Interrupt field off or reserved: an enabled comparator raises nothing
    for (int m = 0; m < 4; m += 3) begin
      wr(cic_pkg::CMP_B_CFG_OFS, cfgWord(1'b1, cic_pkg::REF_NEG_PIN, cic_pkg::HYST_0MV, 2'(m)));
      cmpRaw <= 2'b10;
      tick(8);
      cmpRaw <= 2'b00;
      tick(8);
      rdChk(cic_pkg::IRQ_STAT_OFS, 32'h0, "intoff");
    end
    test_done();
  end

endmodule

`default_nettype wire
